/* File: design/vtl_ctrl.v */
// vector table base protection and interrupt abort control
// assumes: the core reports one instruction per cycle and the pending
// interrupt's enables; registers reached over a plain strobe port
`timescale 1ns/1ps
`include "vtl_consts.vh"

// Contract
// - The locked bit changes only on the write right after both keys.
// - Table base writes need the bit unlocked and interrupts disabled.
// - In one-way mode the locked bit clears once and sets once per reset.
// - In one-way mode a set lock ignores later unlocks until reset.
// - A drop on the last instruction gives one forced no-op, no vector.
// - A drop before the vector point just continues, no forced cycle.
module vtl_ctrl
(
  // clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // one-way configuration strap
  input wire i_vector_lock_one_way,
  // register port
  input wire [`VTL_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // core side
  input wire i_irq_pending,
  input wire i_vector_point,
  input wire i_peripheral_interrupt_enable,
  input wire i_peripheral_interrupt_flag,
  // table base and abort control
  output reg [20:0] o_vector_table_base,
  output reg o_vector_table_locked,
  output reg o_global_interrupt_enable,
  output reg o_vector_take,
  output reg o_forced_no_operation,
  output reg o_pc_hold
);

  // ***********************************
  // lock sequence
  // ***********************************
  wire armed;
  reg one_way;
  reg strap_taken;
  reg cleared_once;
  reg set_once;
  wire lock_sel = (i_addr == `VTL_OFF_LOCK);
  wire lock_wr = i_wr && lock_sel;
  wire want_lock = i_wdata[`VTL_BIT_LOCKED];
  // until the strap is caught the pin itself is used, so a lock write
  // on the very first edge after reset is judged in the right mode
  wire one_way_now = strap_taken ? one_way : i_vector_lock_one_way;

  vtl_key_seq u_key_seq
  (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_wr(i_wr),
    .i_lock_sel(lock_sel),
    .i_wdata(i_wdata),
    .o_armed(armed)
  );

  // one-way permission: a second change of the same kind is refused
  wire allow_clear = !one_way_now ||
                     (!cleared_once && !set_once);
  wire allow_set = !one_way_now || !set_once;
  wire do_clear = lock_wr && armed && !want_lock && allow_clear;
  wire do_set = lock_wr && armed && want_lock && allow_set;

  // strap is caught by a clocked process after reset release
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      one_way <= 1'b0;
      strap_taken <= 1'b0;
    end
    else if (!strap_taken)
    begin
      one_way <= i_vector_lock_one_way;
      strap_taken <= 1'b1;
    end
  end

  // locked bit and one-way history
  // a refused write after the keys still spends them; retry needs new keys
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_vector_table_locked <= `VTL_LOCKED_RESET;
      cleared_once <= 1'b0;
      set_once <= 1'b0;
    end
    else if (do_set)
    begin
      o_vector_table_locked <= 1'b1;
      set_once <= 1'b1;
    end
    else if (do_clear)
    begin
      o_vector_table_locked <= 1'b0;
      cleared_once <= 1'b1;
    end
  end

  // ***********************************
  // control and table base registers
  // ***********************************
  // one select per register; only one address is live per write
  wire sel_intcon = (i_addr == `VTL_OFF_INTCON);
  wire sel_base_lo = (i_addr == `VTL_OFF_BASE_LO);
  wire sel_base_mid = (i_addr == `VTL_OFF_BASE_MID);
  wire sel_base_hi = (i_addr == `VTL_OFF_BASE_HI);
  wire intcon_wr = i_wr && sel_intcon;

  // base writes need unlock and interrupts off; a hazard avoided is a
  // vector fetch seeing a half updated base
  wire base_ok = i_wr && !o_vector_table_locked &&
                 !o_global_interrupt_enable;

  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_global_interrupt_enable <= `VTL_GIE_RESET;
      o_vector_table_base <= `VTL_BASE_RESET;
    end
    else
    begin
      if (intcon_wr)
        o_global_interrupt_enable <= i_wdata[`VTL_BIT_GIE];
      if (base_ok && sel_base_lo)
        o_vector_table_base[7:0] <= i_wdata;
      if (base_ok && sel_base_mid)
        o_vector_table_base[15:8] <= i_wdata;
      if (base_ok && sel_base_hi)
        o_vector_table_base[20:16] <= i_wdata[4:0];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else
    begin
      case (i_addr)
        `VTL_OFF_INTCON:
          o_rdata <= {o_global_interrupt_enable, 7'h00};
        `VTL_OFF_LOCK:
          o_rdata <= {7'h00, o_vector_table_locked};
        `VTL_OFF_BASE_LO:
          o_rdata <= o_vector_table_base[7:0];
        `VTL_OFF_BASE_MID:
          o_rdata <= o_vector_table_base[15:8];
        `VTL_OFF_BASE_HI:
          o_rdata <= {3'h0, o_vector_table_base[20:16]};
        `VTL_OFF_STATUS:
          o_rdata <= {4'h0, set_once, cleared_once, one_way, armed};
        default:
          o_rdata <= 8'h00;
      endcase
    end
  end

  // ***********************************
  // interrupt abort
  // ***********************************
  // the interrupt stays live only while every gate holds; gie is taken
  // as next value so the final instruction's clear is seen in time
  reg next_gie;
  always @*
  begin
    next_gie = o_global_interrupt_enable;
    if (intcon_wr)
      next_gie = i_wdata[`VTL_BIT_GIE];
  end

  wire live = next_gie && i_peripheral_interrupt_enable &&
              i_peripheral_interrupt_flag;
  // the pending request is met at the vectoring point
  wire at_vector = i_vector_point && i_irq_pending;

  // exactly one of the two pulses follows a vectoring point: a live
  // request vectors, one that died on the last instruction is aborted
  reg next_take;
  reg next_forced_no_operation;
  always @*
  begin
    next_take = 1'b0;
    next_forced_no_operation = 1'b0;
    if (at_vector)
    begin
      if (live)
        next_take = 1'b1;
      else
        next_forced_no_operation = 1'b1;
    end
  end

  // earlier drops never reach the vector point, so no cycle is added
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_vector_take <= 1'b0;
      o_forced_no_operation <= 1'b0;
      o_pc_hold <= 1'b0;
    end
    else
    begin
      o_vector_take <= next_take;
      o_forced_no_operation <= next_forced_no_operation;
      o_pc_hold <= next_forced_no_operation;
    end
  end

endmodule

/* File: design/vtl_consts.vh */
// constants for the vector table lock and interrupt abort block
// assumes: included by its bare name from the design files
`ifndef VTL_CONSTS_VH
`define VTL_CONSTS_VH

// register offsets on the plain register port
`define VTL_ADDR_W 4
`define VTL_OFF_INTCON 4'h0
`define VTL_OFF_LOCK 4'h1
`define VTL_OFF_BASE_LO 4'h2
`define VTL_OFF_BASE_MID 4'h3
`define VTL_OFF_BASE_HI 4'h4
`define VTL_OFF_STATUS 4'h5

// field positions
`define VTL_BIT_GIE 7
`define VTL_BIT_LOCKED 0
`define VTL_BIT_ONE_WAY 1

// unlock keys and reset values
`define VTL_KEY_FIRST 8'h55
`define VTL_KEY_SECOND 8'hAA
`define VTL_BASE_RESET 21'h000008
`define VTL_GIE_RESET 1'b0
`define VTL_LOCKED_RESET 1'b0

`endif

/* File: design/vtl_key_seq.v */
// two-key write sequence tracker for the lock register
// assumes: one register write per cycle at most, stands for one instruction
`timescale 1ns/1ps
`include "vtl_consts.vh"

module vtl_key_seq
(
  // clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // observed register traffic
  input wire i_wr,
  input wire i_lock_sel,
  input wire [7:0] i_wdata,
  // armed after both keys, for the very next write only
  output reg o_armed
);

  localparam ST_IDLE = 3'b001;
  localparam ST_KEY1 = 3'b010;
  localparam ST_ARMED = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;

  // any write consumes the sequence step, so keys must be consecutive
  always @*
  begin
    next_state = state;
    if (i_wr)
    begin
      case (state)
        ST_IDLE:
          next_state = (i_lock_sel && i_wdata == `VTL_KEY_FIRST) ?
                       ST_KEY1 : ST_IDLE;
        ST_KEY1:
          next_state = (i_lock_sel && i_wdata == `VTL_KEY_SECOND) ?
                       ST_ARMED : ((i_lock_sel &&
                       i_wdata == `VTL_KEY_FIRST) ? ST_KEY1 : ST_IDLE);
        ST_ARMED:
          next_state = (i_lock_sel && i_wdata == `VTL_KEY_FIRST) ?
                       ST_KEY1 : ST_IDLE;
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  // state register
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // armed output straight from a flop
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_armed <= 1'b0;
    else
      o_armed <= (next_state == ST_ARMED);
  end

endmodule

/* File: test/vtl_ctrl_properties.sv */
// checker: lock keys, base guard and interrupt abort at vtl_ctrl ports
// assumes: bound to vtl_ctrl; at most one bus write per cycle
`timescale 1ns/1ps
`include "vtl_consts.vh"
module vtl_chk
(
  // clock, reset and strap
  input logic i_core_clk,
  input logic i_resetn,
  input logic i_vector_lock_one_way,
  // register port
  input logic [`VTL_ADDR_W-1:0] i_addr,
  input logic [7:0] i_wdata,
  input logic i_wr,
  input logic i_rd,
  input logic [7:0] o_rdata,
  // core side
  input logic i_irq_pending,
  input logic i_vector_point,
  input logic i_peripheral_interrupt_enable,
  input logic i_peripheral_interrupt_flag,
  // results
  input logic [20:0] o_vector_table_base,
  input logic o_vector_table_locked,
  input logic o_global_interrupt_enable,
  input logic o_vector_take,
  input logic o_forced_no_operation,
  input logic o_pc_hold
);
  logic key1;
  logic armed;
  wire lw = i_wr && i_addr == `VTL_OFF_LOCK;
  wire bw = i_wr && i_addr >= `VTL_OFF_BASE_LO && i_addr <= `VTL_OFF_BASE_HI;
  wire vec = i_vector_point && i_irq_pending;
  wire shut = o_vector_table_locked || o_global_interrupt_enable;
  // key history moves on every write, since any write breaks the keys
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      key1 <= 1'h0;
      armed <= 1'h0;
    end
    else if (i_wr)
    begin
      key1 <= lw && i_wdata == `VTL_KEY_FIRST;
      armed <= key1 && lw && i_wdata == `VTL_KEY_SECOND;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  lock_guard_a: assert property (!(lw && armed) |=>
    $stable(o_vector_table_locked)) else $error("locked moved, no keys");
  lock_take_a: assert property (lw && armed && !i_vector_lock_one_way
    && !o_global_interrupt_enable |=> o_vector_table_locked ==
    $past(i_wdata[0])) else $error("keyed lock change lost");
  base_guard_a: assert property (bw && shut |=>
    $stable(o_vector_table_base)) else $error("base written while shut");
  base_write_a: assert property (bw && !shut && i_addr == 4'h2 |=>
    o_vector_table_base[7:0] == $past(i_wdata)) else $error("base lost");
  one_way_a: assert property (i_vector_lock_one_way &&
    o_vector_table_locked |=> o_vector_table_locked) else $error("reopened");
  abort_a: assert property (vec |=> o_forced_no_operation ==
    !(o_global_interrupt_enable && $past(i_peripheral_interrupt_enable) &&
    $past(i_peripheral_interrupt_flag))) else $error("abort wrong");
  vec_one_a: assert property (vec |=> o_vector_take !=
    o_forced_no_operation) else $error("take and no-op clash");
  quiet_a: assert property (!vec |=> !o_forced_no_operation &&
    !o_vector_take) else $error("no-op without vector point");
  hold_a: assert property (o_pc_hold |-> o_forced_no_operation &&
    $past(i_vector_point)) else $error("pc held without no-op");
  cover property (o_forced_no_operation);
  cover property (o_vector_take);
  cover property ($rose(o_vector_table_locked));
endmodule
bind vtl_ctrl vtl_chk u_chk (.*);

/* File: test/vtl_core.sv */
// core model: register writes and reads, pending interrupt, vector point
// assumes: every signal moves just after a rising edge
`timescale 1ns/1ps
`include "vtl_consts.vh"
module vtl_core
(
  // clock
  input logic i_core_clk,
  // register port toward the block
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input logic [7:0] i_rdata,
  // pending interrupt source
  output logic o_pend,
  output logic o_vp,
  output logic o_pie,
  output logic o_flag
);
  initial {o_addr, o_wdata, o_wr, o_rd, o_pend, o_vp, o_pie, o_flag} = '0;
  // strobe stays up until the next call, so writes run back to back
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'h1;
  endtask
  task idle;
    @(posedge i_core_clk);
    {o_wr, o_rd, o_pend, o_vp} <= 4'h0;
  endtask
  // interrupts off first, keys, then the new locked bit; re-enabling
  // is left to the caller so that lock refusals can be seen alone
  task keys(input logic [7:0] d);
    wr(`VTL_OFF_INTCON, 8'h00);
    wr(`VTL_OFF_LOCK, `VTL_KEY_FIRST);
    wr(`VTL_OFF_LOCK, `VTL_KEY_SECOND);
    wr(`VTL_OFF_LOCK, d);
    idle;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'h1;
    idle;
    #1 d = i_rdata;
  endtask
  // last instruction before vectoring, optionally clearing global enable
  task vec(input logic v, input logic pe, input logic fl, input logic clr);
    @(posedge i_core_clk);
    {o_pend, o_vp, o_pie, o_flag, o_wr} <= {1'h1, v, pe, fl, clr};
    {o_addr, o_wdata} <= {`VTL_OFF_INTCON, 8'h00};
    idle;
  endtask
endmodule

/* File: test/test_vtl.sv */
// testbench of the vector table lock and interrupt abort block
// assumes: the core model makes every request; one clock domain
`timescale 1ns/1ps
`include "vtl_consts.vh"
module test_vector_table_lock_and_abort;
  logic i_core_clk, i_resetn, i_vector_lock_one_way, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic i_irq_pending, i_vector_point;
  logic i_peripheral_interrupt_enable, i_peripheral_interrupt_flag;
  logic [20:0] o_vector_table_base;
  logic o_vector_table_locked, o_global_interrupt_enable;
  logic o_vector_take, o_forced_no_operation, o_pc_hold;
  int n_fail = 0;
  int n_compared = 0;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [20:0] b;} vtl_row_t;
  // base bytes, then a read-only and an unmapped place that move nothing
  vtl_row_t rows[5] = '{'{4'h2, 8'h12, 21'h000012},
    '{4'h3, 8'h34, 21'h003412}, '{4'h4, 8'hFF, 21'h1F3412},
    '{4'h5, 8'hFF, 21'h1F3412}, '{4'hF, 8'h77, 21'h1F3412}};
  vtl_ctrl dut (.*);
  vtl_core core (.i_core_clk(i_core_clk), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata),
    .o_pend(i_irq_pending), .o_vp(i_vector_point),
    .o_pie(i_peripheral_interrupt_enable),
    .o_flag(i_peripheral_interrupt_flag));
  initial
  begin
    i_core_clk = 1'h0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task chk(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task rst(input logic ow);
    i_vector_lock_one_way <= ow;
    i_resetn <= 1'h0;
    repeat (8) @(posedge i_core_clk);
    i_resetn <= 1'h1;
  endtask
  // whole run is some 75 cycles; the limit leaves a wide margin
  initial
  begin
    #20000 n_fail++;
    conclude;
  end
  initial
  begin
    rst(1'h0);
    chk(o_vector_table_base, `VTL_BASE_RESET);
    chk({o_vector_table_locked, o_rdata}, 9'h000);
    chk({o_global_interrupt_enable, o_pc_hold}, 2'h0);
    foreach (rows[i])
    begin
      core.wr(rows[i].a, rows[i].d);
      core.idle;
      #1 chk(o_vector_table_base, rows[i].b);
    end
    core.keys(8'h01);
    core.rd(`VTL_OFF_LOCK, d);
    chk({o_vector_table_locked, d[0]}, 2'h3);
    core.wr(`VTL_OFF_BASE_LO, 8'h99);
    // a write between the keys spoils them
    core.wr(`VTL_OFF_LOCK, `VTL_KEY_FIRST);
    core.wr(`VTL_OFF_INTCON, 8'h00);
    core.wr(`VTL_OFF_LOCK, `VTL_KEY_SECOND);
    core.wr(`VTL_OFF_LOCK, 8'h00);
    core.idle;
    #1 chk({o_vector_table_base, o_vector_table_locked}, 22'h3E6825);
    core.keys(8'h00);
    #1 chk(o_vector_table_locked, 1'h0);
    core.wr(`VTL_OFF_INTCON, 8'h80);
    core.wr(`VTL_OFF_BASE_HI, 8'h00);
    core.idle;
    #1 chk(o_vector_table_base, 21'h1F3412);
    chk(o_global_interrupt_enable, 1'h1);
    core.rd(`VTL_OFF_BASE_HI, d);
    chk(d, 8'h1F);
    core.vec(1'h1, 1'h1, 1'h1, 1'h1);
    #1 chk({o_forced_no_operation, o_pc_hold, o_vector_take}, 3'h6);
    @(posedge i_core_clk);
    #1 chk(o_pc_hold, 1'h0);
    core.wr(`VTL_OFF_INTCON, 8'h80);
    core.vec(1'h1, 1'h1, 1'h1, 1'h0);
    #1 chk({o_forced_no_operation, o_vector_take}, 2'h1);
    core.vec(1'h1, 1'h1, 1'h0, 1'h0);
    #1 chk({o_forced_no_operation, o_vector_take}, 2'h2);
    core.vec(1'h0, 1'h0, 1'h1, 1'h0);
    #1 chk({o_forced_no_operation, o_vector_take}, 2'h0);
    rst(1'h1);
    core.keys(8'h00);
    core.keys(8'h01);
    #1 chk(o_vector_table_locked, 1'h1);
    core.keys(8'h00);
    #1 chk(o_vector_table_locked, 1'h1);
    conclude;
  end
endmodule
